/* bench/lsm_ctrl_sva.sv */
// port assertions of the led sink serial mode controller
`timescale 1ns/1ps
module lsm_ctrl_sva
  import lsm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic multi_gate_pin,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [CH_N-1:0] sink_channels,
  input wire logic serial_output,
  input wire logic [CH_N-1:0] gain_config,
  input wire logic multi_strobe_pin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ************************************************************
  // output relations
  // ************************************************************
  gate_blank_a: assert property (multi_gate_pin |=> sink_channels == '0)
    else $error("sinks on while gate high");
  gain_hold_a: assert property (!$past(multi_strobe_pin) |-> $stable(gain_config))
    else $error("gain moved without strobe");
  ser_out_move_a: assert property ($changed(serial_output) |-> $past(ser_clk) && !$past(ser_clk, 2))
    else $error("serial output moved without serial rise");
  reset_clear_a: assert property ($fell(sys_rst) |-> sink_channels == '0 && gain_config == '0 && !irq)
    else $error("outputs not clear after reset");
  blank_ctrl_a: assert property (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_BLANK_BIT] |=> ##1 sink_channels == '0)
    else $error("blank bit did not blank sinks");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  unmapped_zero_a: assert property (reg_rd && reg_addr > REG_SHIFT |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  irq_clear_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq fell without a write");
endmodule

bind lsm_ctrl lsm_ctrl_sva u_sva (.clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
  .multi_gate_pin(multi_gate_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sink_channels(sink_channels), .serial_output(serial_output),
  .gain_config(gain_config), .multi_strobe_pin(multi_strobe_pin), .irq(irq));

/* bench/lsm_host_model.sv */
// controller model driving the serial, strobe and gate pins
`timescale 1ns/1ps
module lsm_host_model
  import lsm_pkg::*;
#(
  parameter int HALF = 2
)
(
  input wire logic clk,
  input wire logic serial_output,
  output logic ser_clk,
  output logic serial_input,
  output logic multi_strobe_pin,
  output logic multi_gate_pin
);
  // idle: clock parked low, gate pulled up, strobe pulled down
  initial begin
    ser_clk = 1'b0;
    serial_input = 1'b0;
    multi_strobe_pin = 1'b0;
    multi_gate_pin = 1'b1;
  end
  // one serial bit; so is the output seen just before the rise
  task automatic bit_io(input logic d, input logic g, input logic s, output logic so);
    ser_clk <= 1'b0;
    serial_input <= d;
    multi_gate_pin <= g;
    multi_strobe_pin <= s;
    repeat (HALF - 1) @(posedge clk);
    @(negedge clk) so = serial_output;
    @(posedge clk) ser_clk <= 1'b1;
    @(posedge clk) serial_input <= ~d; // hold over, line no longer valid
    repeat (HALF - 1) @(posedge clk);
  endtask
  // shifts a word msb first, returns the word that left
  task automatic shift_word(input logic [CH_N-1:0] w, input logic g, output logic [CH_N-1:0] got);
    for (int i = CH_N - 1; i >= 0; i--) begin
      bit_io(w[i], g, 1'b0, got[i]);
    end
  endtask
  task automatic strobe_pulse();
    multi_strobe_pin <= 1'b1;
    repeat (HALF) @(posedge clk);
    multi_strobe_pin <= 1'b0;
    @(posedge clk);
  endtask
  task automatic gate_set(input logic g);
    multi_gate_pin <= g;
    @(posedge clk);
  endtask
  // gate high, one bit low, then pick on the second rise after
  task automatic mode_switch(input logic pick);
    logic so;
    bit_io(1'b0, 1'b1, 1'b0, so);
    bit_io(1'b0, 1'b0, 1'b0, so);
    bit_io(1'b0, 1'b1, 1'b0, so);
    bit_io(1'b0, 1'b1, 1'b0, so);
    bit_io(1'b0, 1'b1, pick, so);
    // the pick pulse outlasts the pick edge by one clock and must still load nothing
    multi_strobe_pin <= 1'b0;
    @(posedge clk);
  endtask
  // gate low for hold cycles, then two capturing rises
  task automatic fault_check(input int hold);
    logic so;
    multi_gate_pin <= 1'b0;
    repeat (hold) @(posedge clk);
    bit_io(1'b0, 1'b0, 1'b0, so);
    bit_io(1'b0, 1'b0, 1'b0, so);
    multi_gate_pin <= 1'b1;
    @(posedge clk);
  endtask
endmodule

/* bench/tb_led_sink_serial_mode_ctrl.sv */
// self-checking bench of the led sink serial mode controller
`timescale 1ns/1ps
module tb_led_sink_serial_mode_ctrl;
  import lsm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [CH_N-1:0] led_fault = '0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ser_clk, serial_input, multi_strobe_pin, multi_gate_pin, serial_output, irq;
  logic [DATA_W-1:0] reg_rdata;
  logic [CH_N-1:0] sink_channels, gain_config, w, g, f, got;
  logic [CH_N-1:0] gain_now = '0;
  logic [ADDR_W-1:0] zero_addr [6] = '{REG_CTRL, REG_STATUS, REG_MASK, REG_LATCH, REG_SHIFT, 8'h18};
  int hold = int'(ED_HOLD_CYC);
  int n_errors = 0;
  int checks = 0;
  int seed = 51910;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  lsm_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .ser_clk(ser_clk), .serial_input(serial_input),
    .multi_strobe_pin(multi_strobe_pin), .multi_gate_pin(multi_gate_pin), .led_fault(led_fault),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sink_channels(sink_channels), .serial_output(serial_output), .gain_config(gain_config), .irq(irq));
  lsm_host_model u_host (.clk(clk), .serial_output(serial_output), .ser_clk(ser_clk),
    .serial_input(serial_input), .multi_strobe_pin(multi_strobe_pin), .multi_gate_pin(multi_gate_pin));

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [DATA_W-1:0] exp_state(input lsm_mode_t m);
    return {28'h0, 1'b0, 1'b1, m}; // strobe idle low, gate idle high
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string n);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk) chk(n, exp, reg_rdata);
    @(posedge clk);
  endtask
  // sel picks sinks, gain or irq once settled
  task automatic out_chk(input string n, input logic [CH_N-1:0] exp, input int sel);
    repeat (2) @(posedge clk);
    @(negedge clk) chk(n, 32'(exp), (sel == 0) ? 32'(sink_channels) : (sel == 1) ? 32'(gain_config) : 32'(irq));
    @(posedge clk);
  endtask
  task automatic gate_sinks(input logic [CH_N-1:0] lat);
    u_host.gate_set(1'b0);
    out_chk("sinks on", lat, 0);
    wr(REG_CTRL, 32'h1);
    out_chk("sinks blank", '0, 0);
    wr(REG_CTRL, 32'h0);
    u_host.gate_set(1'b1);
    out_chk("sinks off", '0, 0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(REG_STATE, 32'hf);
    wr(8'h18, '1);
    foreach (zero_addr[i]) begin
      rd(zero_addr[i], '0, "reset value");
    end
    rd(REG_STATE, exp_state(LSM_NORMAL), "reset state");
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    wr(REG_MASK, 32'hf);
    ce <= 1'b1;
    rd(REG_MASK, '0, "ce freeze");
    for (int it = 0; it < 3; it++) begin
      w = (it == 0) ? 16'h8001 : 16'($random(seed));
      g = 16'($random(seed));
      f = 16'($random(seed));
      wr(REG_STATUS, 32'hf);
      u_host.shift_word(w, 1'b1, got);
      rd(REG_SHIFT, 32'(w), "shift");
      u_host.shift_word(w, 1'b1, got);
      chk("echo", 32'(w), 32'(got));
      u_host.strobe_pulse();
      rd(REG_LATCH, {gain_now, w}, "out latch");
      gate_sinks(w);
      u_host.fault_check(hold);
      rd(REG_SHIFT, 32'({w[13:0], 2'b00}), "no capture");
      rd(REG_STATUS, 32'h0, "no events");
      u_host.mode_switch(1'b1);
      rd(REG_STATE, exp_state(LSM_SPECIAL), "to special");
      rd(REG_LATCH, {gain_now, w}, "pick no load");
      u_host.shift_word(g, 1'b1, got);
      u_host.strobe_pulse();
      gain_now = g;
      out_chk("gain", g, 1);
      rd(REG_LATCH, {g, w}, "gain latch");
      gate_sinks(w);
      rd(REG_STATUS, 32'h3, "events");
      out_chk("irq masked", '0, 2);
      wr(REG_MASK, 32'h2);
      out_chk("irq on", 16'h1, 2);
      wr(REG_STATUS, 32'h2);
      out_chk("irq off", '0, 2);
      rd(REG_STATUS, 32'h1, "w1c");
      wr(REG_MASK, 32'h0);
      led_fault <= f;
      wr(REG_STATUS, 32'hf);
      u_host.fault_check(hold);
      rd(REG_STATUS, 32'h4, "fault");
      u_host.shift_word(w, 1'b1, got);
      chk("fault bits", 32'(f), 32'(got));
      wr(REG_STATUS, 32'hf);
      u_host.fault_check(10);
      rd(REG_STATUS, 32'hc, "short hold");
      u_host.mode_switch(1'b0);
      rd(REG_STATE, exp_state(LSM_NORMAL), "to normal");
      rd(REG_LATCH, {g, w}, "pick no load");
      $display("iteration %0d done", it);
    end
    test_done();
  end

  // watchdog: the run needs about 1900 cycles
  initial begin
    #(CLK_PERIOD_NS * 30000);
    n_errors++;
    test_done();
  end
endmodule

/* hw/lsm_ctrl.sv */
// top of the led sink serial mode controller
//
// Function
// - In normal mode the shift register flows into the output latch while the strobe pin is high, never otherwise.
// - In special mode the strobe loads the gain configuration latch, which is untouched in the other phases.
// - In every phase a low gate pin enables the sinks and a high gate pin blanks them all.
// - A switch pulse on the gate pin enters the switching phase from any phase.
// - Only in special mode a low gate captures per-channel load faults into the shift register.
// - The strobe pulse that picks the next mode during switching loads no latch.
// - In special mode the controller shifts a code and strobes, and the device copies it into the gain latch.
// - Captured fault bits are shifted out on the serial output for the controller to read.
// - Fault detection and gain adjustment work in special mode only.
// - Serial input shifts in on each serial clock rise that captures no faults and the oldest bit leaves on the serial output.
// - A gate pulse one serial clock wide is detected as the switch request.
// - In switching the strobe level picks special mode when high and normal mode when low.
// - A channel conducts only when its latch bit is one and the gate pin is low.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module lsm_ctrl
  import lsm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ser_clk,
  input wire logic serial_input,
  input wire logic multi_strobe_pin,
  input wire logic multi_gate_pin,
  input wire logic [CH_N-1:0] led_fault,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic [CH_N-1:0] sink_channels,
  output logic serial_output,
  output logic [CH_N-1:0] gain_config,
  output logic irq
);

  // ************************************************************
  // helpers
  // ************************************************************

  // address decode, shared by the write and read paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic ser_prev;
    logic strobe_prev;
    logic pick_block;
    logic [CH_N-1:0] out_latch;
    logic [CH_N-1:0] gain;
    logic [ED_CNT_W-1:0] ed_cnt;
    logic blank;
    logic [EVT_N-1:0] status;
    logic [EVT_N-1:0] mask;
    logic irq;
    logic [CH_N-1:0] sink;
    logic [DATA_W-1:0] rdata;
  } lsm_main_st_t;

  localparam lsm_main_st_t MAIN_RST = '{
    ser_prev: 1'b0,
    strobe_prev: 1'b0,
    pick_block: 1'b0,
    out_latch: CH_RST,
    gain: CH_RST,
    ed_cnt: '0,
    blank: 1'b0,
    status: EVT_RST,
    mask: EVT_RST,
    irq: 1'b0,
    sink: CH_RST,
    rdata: DATA_RST
  };

  lsm_main_st_t st_r;
  lsm_main_st_t st_nxt;

  lsm_mode_t mode;
  logic switch_evt;
  logic ser_rise;
  logic [CH_N-1:0] shift_q;
  logic fault_capture;
  logic gain_load_evt;
  logic short_evt;
  logic [EVT_N-1:0] evt_set;
  logic [CH_N-1:0] gate_mask;

  // ************************************************************
  // serial clock edge and mode-qualified events
  // ************************************************************

  // serial clock is sampled as a plain synchronous input
  assign ser_rise = ser_clk && !st_r.ser_prev;

  // fault capture only in special mode, on a serial edge with the gate low
  assign fault_capture = ser_rise && (mode == LSM_SPECIAL) && !multi_gate_pin;

  // one event per gain strobe in special mode
  assign gain_load_evt = (mode == LSM_SPECIAL) && multi_strobe_pin && !st_r.strobe_prev;

  // capture taken before the gate was low for the least hold time
  assign short_evt = fault_capture && (st_r.ed_cnt < ED_HOLD_CYC);

  // sticky event sources
  always_comb begin
    evt_set = EVT_RST;
    evt_set[EVT_SWITCH_BIT] = switch_evt;
    evt_set[EVT_GAIN_BIT] = gain_load_evt;
    evt_set[EVT_FAULT_BIT] = fault_capture;
    evt_set[EVT_SHORT_BIT] = short_evt;
  end

  // ************************************************************
  // submodules
  // ************************************************************

  // phase machine
  lsm_mode_fsm u_fsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .ser_rise(ser_rise),
    .gate(multi_gate_pin),
    .strobe(multi_strobe_pin),
    .mode(mode),
    .switch_evt(switch_evt)
  );

  // shift register: fault capture loads the whole register instead of shifting on that edge
  lsm_shift16 u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .shift_en(ser_rise),
    .load_en(fault_capture),
    .load_data(led_fault),
    .sin(serial_input),
    .q(shift_q)
  );

  // ************************************************************
  // sink gating, one gate term per channel
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_gate
      // conduct only with latch bit one, gate low and no software blank
      assign gate_mask[gi] = st_r.out_latch[gi] && !multi_gate_pin && !st_r.blank;
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ser_prev = ser_clk;
    st_nxt.strobe_prev = multi_strobe_pin;
    // a strobe seen high while switching is the mode pick; it keeps both latches shut until it falls
    st_nxt.pick_block = multi_strobe_pin && ((mode == LSM_SWITCH) || st_r.pick_block);

    // latch paths, transparent while the strobe is high
    unique case (mode)
      LSM_NORMAL: begin
        if (multi_strobe_pin && !st_r.pick_block) begin
          st_nxt.out_latch = shift_q;
        end
      end
      LSM_SPECIAL: begin
        if (multi_strobe_pin && !st_r.pick_block) begin
          st_nxt.gain = shift_q;
        end
      end
      LSM_SWITCH: begin
        // strobe only picks the mode here, no latch moves
      end
      default: begin
      end
    endcase

    // low time of the gate in special mode, saturating
    if ((mode == LSM_SPECIAL) && !multi_gate_pin) begin
      if (st_r.ed_cnt != ED_HOLD_CYC) begin
        st_nxt.ed_cnt = st_r.ed_cnt + 7'h01;
      end
    end else begin
      st_nxt.ed_cnt = '0;
    end

    // register writes
    if (reg_wr) begin
      if (reg_hit(reg_addr, REG_CTRL)) begin
        st_nxt.blank = reg_wdata[CTRL_BLANK_BIT];
      end
      if (reg_hit(reg_addr, REG_MASK)) begin
        st_nxt.mask = reg_wdata[EVT_N-1:0];
      end
    end

    // write one to clear, a new event in the same cycle wins
    if (reg_wr && reg_hit(reg_addr, REG_STATUS)) begin
      st_nxt.status = (st_r.status & ~reg_wdata[EVT_N-1:0]) | evt_set;
    end else begin
      st_nxt.status = st_r.status | evt_set;
    end

    // level interrupt
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    // registered sink drive
    st_nxt.sink = gate_mask;

    // read data stand in the cycle after the strobe only
    st_nxt.rdata = DATA_RST;
    if (reg_rd) begin
      if (reg_hit(reg_addr, REG_CTRL)) begin
        st_nxt.rdata[CTRL_BLANK_BIT] = st_r.blank;
      end else if (reg_hit(reg_addr, REG_STATUS)) begin
        st_nxt.rdata[EVT_N-1:0] = st_r.status;
      end else if (reg_hit(reg_addr, REG_MASK)) begin
        st_nxt.rdata[EVT_N-1:0] = st_r.mask;
      end else if (reg_hit(reg_addr, REG_STATE)) begin
        st_nxt.rdata[1:0] = mode;
        st_nxt.rdata[STATE_GATE_BIT] = multi_gate_pin;
        st_nxt.rdata[STATE_STROBE_BIT] = multi_strobe_pin;
      end else if (reg_hit(reg_addr, REG_LATCH)) begin
        st_nxt.rdata[CH_N-1:0] = st_r.out_latch;
        st_nxt.rdata[LATCH_GAIN_LSB +: CH_N] = st_r.gain;
      end else if (reg_hit(reg_addr, REG_SHIFT)) begin
        st_nxt.rdata[CH_N-1:0] = shift_q;
      end
    end
  end

  // ************************************************************
  // register, frozen while ce is low
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= MAIN_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs, all straight from flip-flops
  // ************************************************************
  assign reg_rdata = st_r.rdata;
  assign sink_channels = st_r.sink;
  assign serial_output = shift_q[CH_N-1];
  assign gain_config = st_r.gain;
  assign irq = st_r.irq;

endmodule

/* hw/lsm_mode_fsm.sv */
// phase machine: switch pulse detection and mode pick
`timescale 1ns/1ps
module lsm_mode_fsm
  import lsm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ser_rise,
  input wire logic gate,
  input wire logic strobe,
  output lsm_mode_t mode,
  output logic switch_evt
);

  typedef struct packed {
    lsm_mode_t mode;
    logic [1:0] hist;
    logic [PICK_CNT_W-1:0] cnt;
    logic evt;
  } lsm_fsm_st_t;

  lsm_fsm_st_t st_r;
  lsm_fsm_st_t st_nxt;
  logic pulse_seen;

  // gate was high, low for one serial edge, then high again
  assign pulse_seen = ser_rise && ({st_r.hist, gate} == 3'b101);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    if (ser_rise) begin
      st_nxt.hist = {st_r.hist[0], gate};
    end
    if (pulse_seen) begin
      st_nxt.mode = LSM_SWITCH;
      st_nxt.cnt = '0;
      st_nxt.evt = 1'b1;
    end else begin
      unique case (st_r.mode)
        LSM_NORMAL: begin
        end
        LSM_SPECIAL: begin
        end
        LSM_SWITCH: begin
          if (ser_rise) begin
            st_nxt.cnt = st_r.cnt + 2'h1;
            if (st_r.cnt + 2'h1 == MODE_PICK_EDGES) begin
              st_nxt.mode = strobe ? LSM_SPECIAL : LSM_NORMAL;
            end
          end
        end
        default: begin
          st_nxt.mode = LSM_NORMAL;
        end
      endcase
    end
  end

  // register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{mode: LSM_NORMAL, hist: GATE_HIST_RST, cnt: '0, evt: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign mode = st_r.mode;
  assign switch_evt = st_r.evt;

endmodule

/* hw/lsm_pkg.sv */
// constants, types and register map of the led sink serial mode controller
package lsm_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20; // 50 mhz system clock
  localparam int ED_HOLD_NS = 2000; // least low time of the gate before fault status is trusted
  localparam int ED_HOLD_CYC_INT = (ED_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ED_CNT_W = 7;
  localparam logic [ED_CNT_W-1:0] ED_HOLD_CYC = ED_HOLD_CYC_INT[ED_CNT_W-1:0];
  localparam int PICK_CNT_W = 2;
  // serial clock edges after the switch pulse at which the strobe level picks the mode
  localparam logic [PICK_CNT_W-1:0] MODE_PICK_EDGES = 2'h2;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int CH_N = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_N = 4;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_LATCH = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SHIFT = 8'h14;

  // field positions
  localparam int CTRL_BLANK_BIT = 0;
  localparam int EVT_SWITCH_BIT = 0;
  localparam int EVT_GAIN_BIT = 1;
  localparam int EVT_FAULT_BIT = 2;
  localparam int EVT_SHORT_BIT = 3;
  localparam int STATE_GATE_BIT = 2;
  localparam int STATE_STROBE_BIT = 3;
  localparam int LATCH_GAIN_LSB = 16;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [CH_N-1:0] CH_RST = 16'h0000;
  localparam logic [1:0] GATE_HIST_RST = 2'h3; // gate idles high (blanked)
  localparam logic [EVT_N-1:0] EVT_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // operating phase
  typedef enum logic [1:0] {
    LSM_NORMAL = 2'b00,
    LSM_SWITCH = 2'b01,
    LSM_SPECIAL = 2'b10
  } lsm_mode_t;

endpackage

/* hw/lsm_shift16.sv */
// sixteen bit shift register with parallel load
`timescale 1ns/1ps
module lsm_shift16
  import lsm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic shift_en,
  input wire logic load_en,
  input wire logic [CH_N-1:0] load_data,
  input wire logic sin,
  output logic [CH_N-1:0] q
);

  typedef struct packed {
    logic [CH_N-1:0] sr;
  } lsm_sh_st_t;

  lsm_sh_st_t st_r;
  lsm_sh_st_t st_nxt;

  // ************************************************************
  // next state: load beats shift
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    if (load_en) begin
      st_nxt.sr = load_data;
    end else if (shift_en) begin
      st_nxt.sr = {st_r.sr[CH_N-2:0], sin};
    end
  end

  // register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{sr: CH_RST};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sr;

endmodule
